// ### design/cl_coef_load.sv
// Purpose: coefficient loading, per-frame set selection and readback
// Assumes: i_sof is a one-cycle start-of-frame pulse on i_clock;
//          split options are static configuration
// Notes:   filters read the main store, readback reads its own copy
`timescale 1ns/1ps
`include "cl_defines.svh"
module cl_coef_load (
  input  wire logic                    i_clock,
  input  wire logic                    i_rstn,
  input  wire cl_pkg::cl_reg_wr_t      i_reg_wr,
  input  wire logic                    i_sof,
  input  wire logic                    i_split_horiz_vert_option,
  input  wire logic                    i_split_luma_chroma_option,
  input  wire cl_pkg::cl_filt_req_t    i_filt_req,
  output logic      [`CL_COEF_W-1:0]   o_filt_coef,
  output logic      [`CL_SET_W-1:0]    o_active_h_set,
  output logic      [`CL_SET_W-1:0]    o_active_v_set,
  output logic                         o_fifo_rdy,
  output logic                         o_load_error,
  output logic                         o_readback_enable_bit,
  output logic                         o_rdbk_rdy,
  output logic      [15:0]             o_rdbk_sel,
  output logic      [15:0]             o_rdbk_addr,
  output logic      [`CL_COEF_W-1:0]   o_rdbk_coef
);

  // register decode
  wire wr_coef  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_COEF_DATA;
  wire wr_set   = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_SET_ADDR;
  wire wr_ctrl  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_CONTROL;
  wire wr_hset  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_H_SET;
  wire wr_vset  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_V_SET;
  wire wr_rsel  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_RDBK_SEL;
  wire wr_raddr = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_RDBK_ADDR;
  wire [`CL_SET_W-1:0] wdata_set = i_reg_wr.data[`CL_SET_W-1:0];
  wire ctrl_rden = i_reg_wr.data[`CL_CTRL_RDEN_BIT];

  cl_pkg::cl_state_t state;
  cl_pkg::cl_state_t next_state;

  logic [`CL_SET_W-1:0]  h_set_reg;
  logic [`CL_SET_W-1:0]  v_set_reg;
  logic [`CL_SET_W-1:0]  dest_set;
  logic [`CL_WORD_W:0]   load_cnt;
  logic                  load_started;
  logic                  set_ready;
  logic                  frame_seen;
  logic [`CL_WORD_W-1:0] cp_ptr;
  logic [31:0]           fifo_mem [0:`CL_FIFO_DEPTH-1];
  logic [`CL_COEF_W-1:0] coef_mem [0:`CL_MEM_DEPTH-1];
  logic                  rb_req;
  logic                  fill_used;
  logic [`CL_RB_W-1:0]   fill_cnt;
  logic [`CL_SET_W-1:0]  fill_set;
  logic [1:0]            fill_bank;
  logic                  rb_tap_ok;
  logic [`CL_RB_W-1:0]   rb_raddr;
  logic [`CL_COEF_W-1:0] rb_q;

  // expected words for one set, by sharing options
  wire [1:0] nbank_log = {1'b0, i_split_horiz_vert_option}
                       + {1'b0, i_split_luma_chroma_option};
  wire [`CL_WORD_W:0] exp_words
    = `CL_WORDS_PER_BANK << nbank_log;

  // data words are taken while the FIFO is open and the set is short
  wire accept = wr_coef && o_fifo_rdy && !set_ready
              && load_cnt < exp_words;
  wire last_word = accept
                 && (load_cnt + `CL_WORD_W'(1)) == exp_words;
  wire [`CL_WORD_W+1:0] coefs_seen = {load_cnt, 1'b0};
  wire short_load = 32'(coefs_seen) < `CL_MIN_COEFS;

  // copy addressing: word index splits into bank slot, phase, pair
  wire [31:0]            cp_word  = fifo_mem[cp_ptr];
  wire [1:0]             cp_slot  = cp_ptr[`CL_WORD_W-1:`CL_WORD_W-2];
  wire [`CL_PHASE_W-1:0] cp_phase = cp_ptr[3:2];
  wire [1:0]             cp_pair  = cp_ptr[1:0];
  // skipped banks compress the slot sequence
  wire [1:0] cp_bank = i_split_luma_chroma_option ? cp_slot
                                                  : {cp_slot[0], 1'b0};
  wire [`CL_TAP_W-1:0] tap_lo = {cp_pair, 1'b0};
  wire [`CL_TAP_W-1:0] tap_hi = {cp_pair, 1'b1};
  wire hi_valid = 32'(tap_hi) < `CL_NUM_TAPS;
  // bank bits on top: H in the lower half, luma low within each half
  wire [`CL_MEM_W-1:0] idx_lo = {cp_bank, dest_set, cp_phase, tap_lo};
  wire [`CL_MEM_W-1:0] idx_hi = {cp_bank, dest_set, cp_phase, tap_hi};
  wire copying  = state == cl_pkg::CL_ST_COPY;
  wire cp_last  = copying
                && ({1'b0, cp_ptr} + `CL_WORD_W'(1)) == exp_words;
  wire copy_go  = i_sof && state == cl_pkg::CL_ST_IDLE && set_ready;

  // readback fill
  wire filling   = state == cl_pkg::CL_ST_FILL;
  wire fill_go   = state == cl_pkg::CL_ST_IDLE && !copy_go && rb_req
                 && !fill_used && o_readback_enable_bit;
  wire fill_last = filling && fill_cnt == `CL_RB_LAST;
  wire fill_abort = filling && !o_readback_enable_bit;
  wire [`CL_MEM_W-1:0] fill_idx = {fill_bank, fill_set, fill_cnt};
  wire rden_rise = wr_ctrl && ctrl_rden && !o_readback_enable_bit;

  always_comb begin
    next_state = state;
    case (state)
      cl_pkg::CL_ST_IDLE: begin
        if (copy_go) begin
          next_state = cl_pkg::CL_ST_COPY;
        end else if (fill_go) begin
          next_state = cl_pkg::CL_ST_FILL;
        end
      end
      cl_pkg::CL_ST_COPY: begin
        if (cp_last) begin
          next_state = cl_pkg::CL_ST_IDLE;
        end
      end
      cl_pkg::CL_ST_FILL: begin
        if (fill_last || fill_abort) begin
          next_state = cl_pkg::CL_ST_IDLE;
        end
      end
      default: next_state = cl_pkg::CL_ST_IDLE;
    endcase
  end

  // FIFO-ready: open after a frame start, closed while a set waits
  wire next_set_ready = wr_set ? 1'b0
                      : cp_last ? 1'b0
                      : last_word ? 1'b1 : set_ready;
  wire next_frame_seen = frame_seen || i_sof;
  wire next_fifo_rdy = next_frame_seen && !next_set_ready
                     && next_state != cl_pkg::CL_ST_COPY;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state      <= cl_pkg::CL_ST_IDLE;
      set_ready  <= 1'b0;
      frame_seen <= 1'b0;
      o_fifo_rdy <= 1'b0;
    end else begin
      state      <= next_state;
      set_ready  <= next_set_ready;
      frame_seen <= next_frame_seen;
      o_fifo_rdy <= next_fifo_rdy;
    end
  end

  // loading sequence; set address write restarts it
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      dest_set     <= '0;
      load_cnt     <= '0;
      load_started <= 1'b0;
      o_load_error <= 1'b0;
    end else if (wr_set) begin
      dest_set     <= wdata_set;
      load_cnt     <= '0;
      load_started <= 1'b1;
      o_load_error <= load_started && short_load;
    end else if (accept) begin
      // count survives the copy so a later restart still sees it
      load_cnt     <= load_cnt + `CL_WORD_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (accept) begin
      fifo_mem[load_cnt[`CL_WORD_W-1:0]] <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn || !copying) begin
      cp_ptr <= '0;
    end else begin
      cp_ptr <= cp_ptr + `CL_WORD_W'(1);
    end
  end

  // main store: each copy cycle writes both halves of one word, except pair 3, whose upper half is dropped and tap 7 written as zero
  genvar g;
  generate
    for (g = 0; g < `CL_MEM_DEPTH; g++) begin : g_coef
      always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
          coef_mem[g] <= `CL_REG_RESET;
        end else if (copying && idx_lo == `CL_MEM_W'(g)) begin
          coef_mem[g] <= cp_word[15:0];
        end else if (copying && idx_hi == `CL_MEM_W'(g)) begin
          coef_mem[g] <= hi_valid ? cp_word[31:16] : `CL_REG_RESET;
        end
      end
    end
  endgenerate

  // set selection takes effect at the next frame start
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      h_set_reg      <= '0;
      v_set_reg      <= '0;
      o_active_h_set <= '0;
      o_active_v_set <= '0;
    end else begin
      if (wr_hset) h_set_reg <= wdata_set;
      if (wr_vset) v_set_reg <= wdata_set;
      if (i_sof) begin
        o_active_h_set <= h_set_reg;
        o_active_v_set <= v_set_reg;
      end
    end
  end

  // filter port: shared banks fold onto horizontal and luma
  wire [1:0] f_bank = {i_filt_req.bank[1] & i_split_horiz_vert_option,
                       i_filt_req.bank[0] & i_split_luma_chroma_option};
  wire [`CL_SET_W-1:0] f_set = f_bank[1] ? o_active_v_set : o_active_h_set;
  wire [`CL_MEM_W-1:0] f_idx = {f_bank, f_set, i_filt_req.phase,
                                i_filt_req.tap};

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_filt_coef <= `CL_REG_RESET;
    end else begin
      o_filt_coef <= coef_mem[f_idx];
    end
  end

  // readback control and fill
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_readback_enable_bit <= 1'b0;
      o_rdbk_sel            <= `CL_REG_RESET;
      o_rdbk_addr           <= `CL_REG_RESET;
      rb_req                <= 1'b0;
      fill_set              <= '0;
      fill_bank             <= `CL_BANK_HY;
    end else begin
      if (wr_ctrl) o_readback_enable_bit <= ctrl_rden;
      if (wr_rsel) o_rdbk_sel  <= i_reg_wr.data[15:0];
      if (wr_raddr) o_rdbk_addr <= i_reg_wr.data[15:0];
      if (rden_rise) begin
        rb_req    <= 1'b1;
        fill_set  <= o_rdbk_sel[`CL_SEL_SET_LSB +: `CL_SET_W];
        fill_bank <= o_rdbk_sel[`CL_SEL_BANK_LSB +: 2];
      end else if (fill_last || (wr_ctrl && !ctrl_rden)) begin
        rb_req    <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      fill_used  <= 1'b0;
      o_rdbk_rdy <= 1'b0;
      fill_cnt   <= '0;
    end else begin
      if (fill_last) begin
        fill_used <= 1'b1;
      end else if (i_sof) begin
        fill_used <= 1'b0;
      end
      if (fill_last) begin
        o_rdbk_rdy <= 1'b1;
      end else if (!o_readback_enable_bit || rden_rise) begin
        o_rdbk_rdy <= 1'b0;
      end
      fill_cnt <= filling ? fill_cnt + `CL_RB_W'(1) : '0;
    end
  end

  // readback address to store index; taps past the store read as zero
  assign rb_tap_ok = !o_rdbk_addr[`CL_ADDR_TAP_MSB];
  assign rb_raddr  = {o_rdbk_addr[`CL_ADDR_PHASE_LSB +: `CL_PHASE_W],
                      o_rdbk_addr[`CL_ADDR_TAP_LSB +: `CL_TAP_W]};

  cl_rdbk_ram u_rdbk_ram (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_we    (filling && o_readback_enable_bit),
    .i_waddr (fill_cnt),
    .i_wdata (coef_mem[fill_idx]),
    .i_raddr (rb_raddr),
    .o_rdata (rb_q)
  );

  // output holds its value while reads are not allowed
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdbk_coef <= `CL_REG_RESET;
    end else if (o_readback_enable_bit && o_rdbk_rdy) begin
      o_rdbk_coef <= rb_tap_ok ? rb_q : `CL_REG_RESET;
    end
  end

endmodule : cl_coef_load

// ### design/cl_defines.svh
// Purpose: constants of the coefficient load and readback block
// Assumes: one small configuration of phases, taps and sets
// Notes:   sizes are fixed; change them together
`ifndef CL_DEFINES_SVH
`define CL_DEFINES_SVH

`define CL_MAX_PHASES      4
`define CL_PHASE_W         2
`define CL_NUM_TAPS        7
`define CL_TAP_W           3
`define CL_SET_W           1
`define CL_WORD_W          6
`define CL_FIFO_DEPTH      64
`define CL_MEM_W           8
`define CL_MEM_DEPTH       256
`define CL_RB_W            5
`define CL_RB_DEPTH        32
`define CL_RB_LAST         5'h1f
`define CL_WORDS_PER_BANK  7'h10
`define CL_MIN_COEFS       (2 * `CL_MAX_PHASES * `CL_NUM_TAPS)
`define CL_COEF_W          16

`define CL_CTRL_RDEN_BIT   3
`define CL_SEL_SET_LSB     8
`define CL_SEL_BANK_LSB    0
`define CL_ADDR_PHASE_LSB  8
`define CL_ADDR_TAP_MSB    3
`define CL_ADDR_TAP_LSB    0
`define CL_REG_RESET       16'h0000

`define CL_BANK_HY         2'h0
`define CL_BANK_HC         2'h1
`define CL_BANK_VY         2'h2
`define CL_BANK_VC         2'h3

`endif

// ### design/cl_pkg.sv
// Purpose: shared types of the coefficient load and readback block
// Assumes: cl_defines.svh gives the phase and tap widths
// Notes:   register selects stand in for a register port decode
`include "cl_defines.svh"
package cl_pkg;

  typedef enum logic [2:0] {
    CL_REG_COEF_DATA = 3'h0,
    CL_REG_SET_ADDR  = 3'h1,
    CL_REG_CONTROL   = 3'h2,
    CL_REG_H_SET     = 3'h3,
    CL_REG_V_SET     = 3'h4,
    CL_REG_RDBK_SEL  = 3'h5,
    CL_REG_RDBK_ADDR = 3'h6
  } cl_reg_sel_t;

  typedef struct packed {
    logic        valid;
    cl_reg_sel_t sel;
    logic [31:0] data;
  } cl_reg_wr_t;

  typedef struct packed {
    logic [1:0]             bank;
    logic [`CL_PHASE_W-1:0] phase;
    logic [`CL_TAP_W-1:0]   tap;
  } cl_filt_req_t;

  typedef enum logic [1:0] {
    CL_ST_IDLE = 2'h0,
    CL_ST_COPY = 2'h1,
    CL_ST_FILL = 2'h2
  } cl_state_t;

endpackage : cl_pkg

// ### design/cl_rdbk_ram.sv
// Purpose: readback dual-port store, one bank of coefficients
// Assumes: one write port, one registered read port, same clock
// Notes:   contents are not reset, only the read register is
`timescale 1ns/1ps
`include "cl_defines.svh"
module cl_rdbk_ram (
  input  wire logic                   i_clock,
  input  wire logic                   i_rstn,
  input  wire logic                   i_we,
  input  wire logic [`CL_RB_W-1:0]    i_waddr,
  input  wire logic [`CL_COEF_W-1:0]  i_wdata,
  input  wire logic [`CL_RB_W-1:0]    i_raddr,
  output logic      [`CL_COEF_W-1:0]  o_rdata
);

  logic [`CL_COEF_W-1:0] mem [0:`CL_RB_DEPTH-1];

  genvar g;
  generate
    for (g = 0; g < `CL_RB_DEPTH; g++) begin : g_ent
      always_ff @(posedge i_clock) begin
        if (i_we && i_waddr == `CL_RB_W'(g)) begin
          mem[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdata <= `CL_REG_RESET;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : cl_rdbk_ram

// ### test/cl_coef_load_monitor.sv
// Purpose: port checker for the coefficient load block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached to every instance by bind
`timescale 1ns/1ps
`include "cl_defines.svh"
module cl_coef_load_monitor (
  input wire logic                  i_clock,
  input wire logic                  i_rstn,
  input wire cl_pkg::cl_reg_wr_t    i_reg_wr,
  input wire logic                  i_sof,
  input wire logic [`CL_SET_W-1:0]  o_active_h_set,
  input wire logic                  o_fifo_rdy,
  input wire logic                  o_load_error,
  input wire logic                  o_readback_enable_bit,
  input wire logic                  o_rdbk_rdy,
  input wire logic [15:0]           o_rdbk_sel,
  input wire logic [`CL_COEF_W-1:0] o_rdbk_coef
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic seen_sof;
  wire wr_rsel = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_RDBK_SEL;
  wire wr_ctl  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_CONTROL;
  wire wr_set  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_SET_ADDR;
  wire wr_dat  = i_reg_wr.valid && i_reg_wr.sel == cl_pkg::CL_REG_COEF_DATA;

  always_ff @(posedge i_clock) begin
    if (!i_rstn)
      seen_sof <= 1'b0;
    else if (i_sof)
      seen_sof <= 1'b1;
  end

  a_set_on_frame: assert property (
    $past(i_rstn) && $changed(o_active_h_set) |-> $past(i_sof))
    else $error("active set moved off frame start");
  a_sel_stored: assert property (
    wr_rsel |=> o_rdbk_sel == $past(i_reg_wr.data[15:0]))
    else $error("readback select not stored");
  a_enable_stored: assert property (
    wr_ctl |=> o_readback_enable_bit == $past(i_reg_wr.data[3]))
    else $error("readback enable not stored");
  a_rdy_after_fill: assert property (
    $rose(o_rdbk_rdy) |-> o_readback_enable_bit
      && $past(o_readback_enable_bit, 30))
    else $error("readback ready without full fill");
  a_coef_holds: assert property (
    (!o_rdbk_rdy) [*4] |=> $stable(o_rdbk_coef))
    else $error("readback output moved while not ready");
  a_error_cause: assert property (
    $past(i_rstn) && $changed(o_load_error)
      |-> $past(wr_set) || $past(wr_set, 2))
    else $error("load error moved without set address write");
  a_fifo_full: assert property (
    $past(i_rstn) && $fell(o_fifo_rdy) |-> $past(wr_dat) || $past(wr_set))
    else $error("fifo ready dropped without a write");
  a_fifo_first: assert property (
    !seen_sof |-> !o_fifo_rdy)
    else $error("fifo ready before first frame");

  c_error: cover property (o_load_error);
  c_rdy: cover property ($rose(o_rdbk_rdy));
  c_full: cover property ($fell(o_fifo_rdy));
endmodule : cl_coef_load_monitor

bind cl_coef_load cl_coef_load_monitor i_mon (.i_clock, .i_rstn,
  .i_reg_wr, .i_sof, .o_active_h_set, .o_fifo_rdy, .o_load_error,
  .o_readback_enable_bit, .o_rdbk_rdy, .o_rdbk_sel, .o_rdbk_coef);

// ### test/cl_host_model.sv
// Purpose: host side of the register port, one write per call
// Assumes: writes launch just after a rising edge
// Notes:   an idle port shows inverted data; a second idle in a row restores the stale word
`timescale 1ns/1ps
module cl_host_model (
  input  wire logic          i_clock,
  output cl_pkg::cl_reg_wr_t o_reg_wr
);
  initial o_reg_wr = '0;

  // set address first, then data words in phase and tap order
  task automatic wr(input logic [2:0] sel, input logic [31:0] data);
    @(posedge i_clock);
    o_reg_wr <= '{1'b1, cl_pkg::cl_reg_sel_t'(sel), data};
  endtask : wr

  task automatic idle();
    @(posedge i_clock);
    o_reg_wr.valid <= 1'b0;
    o_reg_wr.data  <= ~o_reg_wr.data;
  endtask : idle
endmodule : cl_host_model

// ### test/tb.sv
// Purpose: self-checking bench for the coefficient load block
// Assumes: two split settings, each applied under its own reset
// Notes:   model arrays hold what each set should contain
`timescale 1ns/1ps
module tb;
  logic                 i_clock;
  logic                 i_rstn;
  logic                 i_sof;
  cl_pkg::cl_reg_wr_t   reg_wr;
  cl_pkg::cl_filt_req_t i_filt_req;
  logic [15:0]          filt_coef, rb_sel, rb_coef, rb_addr;
  logic                 h_set, v_set, fifo_rdy, load_err, rb_rdy;
  logic                 rb_en, split_hv, split_yc;
  int                   error_cnt, tests_run;
  int                   mdl [2][4][4][7];
  int                   banks[$];

  cl_host_model host (.i_clock(i_clock), .o_reg_wr(reg_wr));
  cl_coef_load i_cl_coef_load (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_reg_wr(reg_wr), .i_sof(i_sof), .i_split_horiz_vert_option(split_hv),
    .i_split_luma_chroma_option(split_yc), .i_filt_req(i_filt_req),
    .o_filt_coef(filt_coef), .o_active_h_set(h_set),
    .o_active_v_set(v_set), .o_fifo_rdy(fifo_rdy),
    .o_load_error(load_err), .o_readback_enable_bit(rb_en),
    .o_rdbk_rdy(rb_rdy), .o_rdbk_sel(rb_sel), .o_rdbk_addr(rb_addr),
    .o_rdbk_coef(rb_coef));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // 0: loading fifo ready, 1: readback ready
  task automatic wait_for(input int which);
    for (int n = 0; n < 400; n++) begin
      @(posedge i_clock);
      #1;
      if (which == 0 ? fifo_rdy === 1'b1 : rb_rdy === 1'b1)
        return;
    end
    chk("wait", 0, 1);
    complete_run();
  endtask : wait_for

  task automatic frame();
    @(posedge i_clock) i_sof <= 1'b1;
    @(posedge i_clock) i_sof <= 1'b0;
  endtask : frame

  // word w: bank slot w/16, phase (w/4)%4, tap pair w%4
  task automatic load(input int set, input int nw);
    logic [15:0] lo, hi;
    host.wr(3'h1, set);
    for (int w = 0; w < nw; w++) begin
      lo = $urandom;
      hi = $urandom;
      mdl[set][banks[w/16]][(w/4)%4][2*(w%4)] = lo;
      // tap count is odd: upper half of last word must be dropped
      if (w % 4 < 3)
        mdl[set][banks[w/16]][(w/4)%4][2*(w%4)+1] = hi;
      host.wr(3'h0, {hi, lo});
    end
    host.idle();
  endtask : load

  task automatic f_chk(input int b, p, t);
    @(posedge i_clock) i_filt_req <= '{b[1:0], p[1:0], t[2:0]};
    @(posedge i_clock);
    #1;
    chk("filter coef", filt_coef, mdl[1][b][p][t]);
  endtask : f_chk

  task automatic rb_chk(input int p, t, exp);
    host.wr(3'h6, {16'h0, p[7:0], 4'h0, t[3:0]});
    host.idle();
    repeat (4) @(posedge i_clock);
    #1;
    chk("readback coef", rb_coef, exp);
    chk("readback addr", rb_addr, {p[7:0], 4'h0, t[3:0]});
  endtask : rb_chk

  task automatic ctl_sel(input logic [31:0] sel);
    host.wr(3'h2, 32'h0);
    host.wr(3'h5, sel);
    host.wr(3'h2, 32'h8);
    host.idle();
  endtask : ctl_sel

  initial begin
    i_rstn = 1'b0;
    i_sof = 1'b0;
    i_filt_req = '0;
    split_hv = 1'b1;
    split_yc = 1'b0;
    void'($urandom(41));
    for (int b = 0; b < 4; b++)
      if (!b[0]) banks.push_back(b);
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    #1;
    chk("fifo at reset", fifo_rdy, 0);
    frame();
    wait_for(0);
    load(1, 16 * banks.size());
    #1;
    chk("fifo full", fifo_rdy, 0);
    host.wr(3'h3, 32'h1);
    host.wr(3'h4, 32'h1);
    host.idle();
    #1;
    chk("h set early", h_set, 0);
    frame();
    wait_for(0);
    chk("h set", h_set, 1);
    chk("v set", v_set, 1);
    foreach (banks[i])
      for (int p = 0; p < 4; p++)
        for (int t = 0; t < 7; t++)
          f_chk(banks[i], p, t);
    $display("test load done");
    ctl_sel(32'h0102);
    wait_for(1);
    chk("readback select", rb_sel, 16'h0102);
    chk("readback enable", rb_en, 1);
    for (int p = 0; p < 4; p++)
      for (int t = 0; t < 7; t++)
        rb_chk(p, t, mdl[1][2][p][t]);
    rb_chk(1, 8, 0);
    f_chk(2, 1, 4);
    ctl_sel(32'h0100);
    repeat (60) @(posedge i_clock);
    #1;
    chk("second fill", rb_rdy, 0);
    rb_chk(0, 1, 0);
    frame();
    wait_for(1);
    rb_chk(2, 3, mdl[1][0][2][3]);
    $display("test readback done");
    load(0, 3);
    @(posedge i_clock);
    #1;
    chk("no error", load_err, 2 * 32 < 2 * 4 * 7);
    host.wr(3'h1, 32'h0);
    host.idle();
    @(posedge i_clock);
    #1;
    chk("short load", load_err, 2 * 3 < 2 * 4 * 7);
    $display("test error done");
    // shared H/V, split luma/chroma: banks HY then HC only
    @(posedge i_clock) i_rstn <= 1'b0;
    split_hv <= 1'b0;
    split_yc <= 1'b1;
    banks = {0, 1};
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    #1;
    chk("fifo after reset", fifo_rdy, 0);
    chk("set after reset", h_set, 0);
    frame();
    wait_for(0);
    load(1, 16 * banks.size());
    host.wr(3'h3, 32'h1);
    host.wr(3'h4, 32'h1);
    host.idle();
    frame();
    wait_for(0);
    for (int p = 0; p < 4; p++)
      for (int t = 0; t < 7; t++) begin
        mdl[1][3][p][t] = mdl[1][1][p][t];
        f_chk(1, p, t);
        f_chk(3, p, t);
      end
    $display("test shared done");
    complete_run();
  end
endmodule : tb
